// [verilog/ahwp_port.sv]
/*
 Asynchronous host bus port with wait-state generation on the ready pin.
 Assumes host pins are asynchronous, the core answers a read one cycle
 after core_rd_o, and the bus wire is resolved from data_oe_o outside.
*/
`include "ahwp_params.svh"
`default_nettype none
module ahwp_port #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic addr_qualifier_i,
    input wire logic [3:0] byte_lane_enables_n_i,
    input wire logic addr_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic data_port_select_n_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic async_ready_o,
    input wire logic turbo_mode_i,
    output logic core_rd_o,
    output logic core_wr_o,
    output logic [ADDR_W-1:0] core_addr_o,
    output logic [3:0] core_be_o,
    output logic [DATA_W-1:0] core_wdata_o,
    output logic core_qdata_o,
    input wire logic [DATA_W-1:0] core_rdata_i
);
    import ahwp_pkg::*;

    localparam int SYNC_W = ADDR_W + DATA_W + 9;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_sync;
    logic [ADDR_W-1:0] s_addr;
    logic s_qual;
    logic [3:0] s_be_n;
    logic s_as_n;
    logic s_rd_n;
    logic s_wr_n;
    logic s_dcs_n;
    logic [DATA_W-1:0] s_data;

    ahwp_state_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [ADDR_W-1:0] lat_addr, next_lat_addr;
    logic lat_qual, next_lat_qual;
    logic [3:0] lat_be_n, next_lat_be_n;
    logic wr_n_prev, next_wr_n_prev;
    logic rd_cap, next_rd_cap;
    logic pend_wr, next_pend_wr;
    logic [ADDR_W-1:0] pend_addr, next_pend_addr;
    logic [3:0] pend_be_n, next_pend_be_n;
    logic [DATA_W-1:0] pend_data, next_pend_data;
    ahwp_cls_t pend_cls, next_pend_cls;
    logic [DATA_W-1:0] next_data;
    logic next_oe;
    logic next_ready;
    logic next_core_rd;
    logic next_core_wr;
    logic [ADDR_W-1:0] next_core_addr;
    logic [3:0] next_core_be;
    logic [DATA_W-1:0] next_core_wdata;
    logic next_core_qdata;

    logic [ADDR_W-1:0] eff_addr;
    logic eff_qual;
    logic [3:0] eff_be_n;
    ahwp_cls_t eff_cls;
    logic wr_event;

    function automatic ahwp_cls_t ahwp_classify(input logic [ADDR_W-1:0] addr, input logic qual_n,
                                                input logic dcs_n);
        ahwp_cls_t cls;
        cls = AHWP_CLS_PLAIN;
        if (!dcs_n)
            cls = AHWP_CLS_QDATA;
        else if (qual_n)
            cls = AHWP_CLS_NONE;
        else if (addr == ADDR_W'(`AHWP_BANK_SEL_ADDR))
            cls = AHWP_CLS_BANK;
        else if (addr == ADDR_W'(`AHWP_QDATA_ADDR))
            cls = AHWP_CLS_QDATA;
        return cls;
    endfunction

    // Only the queue data register is slow; everything else answers at once
    function automatic logic [2:0] ahwp_wait_cyc(input ahwp_cls_t cls, input logic is_rd, input logic turbo);
        logic [2:0] n;
        n = 3'h0;
        if (cls == AHWP_CLS_QDATA)
        begin
            if (!is_rd)
                n = 3'(`AHWP_WR_WAIT_CYC);
            else if (turbo)
                n = 3'(`AHWP_RD_WAIT_TURBO_CYC);
            else
                n = 3'(`AHWP_RD_WAIT_NORMAL_CYC);
        end
        return n;
    endfunction

    assign pins_raw = {addr_i, addr_qualifier_i, byte_lane_enables_n_i, addr_strobe_n_i, read_strobe_n_i,
                       write_strobe_n_i, data_port_select_n_i, data_i};

    ahwp_sync #(
        .WIDTH(SYNC_W)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(pins_raw),
        .q_o(pins_sync)
    );

    assign {s_addr, s_qual, s_be_n, s_as_n, s_rd_n, s_wr_n, s_dcs_n, s_data} = pins_sync;

    // Strobe low is transparent, so a tied-low strobe simply follows the pins
    assign eff_addr = s_as_n ? lat_addr : s_addr;
    assign eff_qual = s_as_n ? lat_qual : s_qual;
    assign eff_be_n = s_as_n ? lat_be_n : s_be_n;
    assign eff_cls = ahwp_classify(eff_addr, eff_qual, s_dcs_n);
    assign wr_event = !wr_n_prev && s_wr_n;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_lat_addr = s_as_n ? lat_addr : s_addr;
        next_lat_qual = s_as_n ? lat_qual : s_qual;
        next_lat_be_n = s_as_n ? lat_be_n : s_be_n;
        next_wr_n_prev = s_wr_n;
        next_rd_cap = core_rd_o;
        next_pend_wr = pend_wr;
        next_pend_addr = pend_addr;
        next_pend_be_n = pend_be_n;
        next_pend_data = pend_data;
        next_pend_cls = pend_cls;
        next_data = rd_cap ? core_rdata_i : data_o;
        next_oe = data_oe_o;
        next_ready = async_ready_o;
        next_core_rd = 1'b0;
        next_core_wr = 1'b0;
        next_core_addr = core_addr_o;
        next_core_be = core_be_o;
        next_core_wdata = core_wdata_o;
        next_core_qdata = core_qdata_o;
        unique case (state)
            AHWP_IDLE:
            begin
                next_ready = 1'b1;
                next_oe = 1'b0;
                if (pend_wr)
                begin
                    // Write that arrived during the previous wait
                    next_pend_wr = 1'b0;
                    next_core_wr = 1'b1;
                    next_core_addr = pend_addr;
                    next_core_be = ~pend_be_n;
                    next_core_wdata = pend_data;
                    next_core_qdata = (pend_cls == AHWP_CLS_QDATA);
                    next_cnt = ahwp_wait_cyc(pend_cls, 1'b0, turbo_mode_i) - 3'h1;
                    if (ahwp_wait_cyc(pend_cls, 1'b0, turbo_mode_i) != 3'h0)
                    begin
                        next_state = AHWP_WR_WAIT;
                        next_ready = 1'b0;
                    end
                    if (wr_event && eff_cls != AHWP_CLS_NONE)
                    begin
                        next_pend_wr = 1'b1;
                        next_pend_addr = eff_addr;
                        next_pend_be_n = eff_be_n;
                        next_pend_data = s_data;
                        next_pend_cls = eff_cls;
                    end
                end
                else if (wr_event && eff_cls != AHWP_CLS_NONE)
                begin
                    next_core_wr = 1'b1;
                    next_core_addr = eff_addr;
                    next_core_be = ~eff_be_n;
                    next_core_wdata = s_data;
                    next_core_qdata = (eff_cls == AHWP_CLS_QDATA);
                    next_cnt = ahwp_wait_cyc(eff_cls, 1'b0, turbo_mode_i) - 3'h1;
                    if (ahwp_wait_cyc(eff_cls, 1'b0, turbo_mode_i) != 3'h0)
                    begin
                        next_state = AHWP_WR_WAIT;
                        next_ready = 1'b0;
                    end
                end
                else if (!s_rd_n && eff_cls != AHWP_CLS_NONE)
                begin
                    next_core_rd = 1'b1;
                    next_core_addr = eff_addr;
                    next_core_be = ~eff_be_n;
                    next_core_qdata = (eff_cls == AHWP_CLS_QDATA);
                    next_oe = 1'b1;
                    next_cnt = ahwp_wait_cyc(eff_cls, 1'b1, turbo_mode_i) - 3'h1;
                    if (ahwp_wait_cyc(eff_cls, 1'b1, turbo_mode_i) != 3'h0)
                    begin
                        next_state = AHWP_RD_WAIT;
                        next_ready = 1'b0;
                    end
                    else
                    begin
                        next_state = AHWP_RD_HOLD;
                    end
                end
            end
            AHWP_RD_WAIT:
            begin
                // Data lands two edges after the core request, never after ready rises
                if (cnt == 3'h0)
                begin
                    next_ready = 1'b1;
                    next_state = AHWP_RD_HOLD;
                end
                else
                begin
                    next_cnt = cnt - 3'h1;
                end
            end
            AHWP_RD_HOLD:
            begin
                if (s_rd_n)
                begin
                    next_oe = 1'b0;
                    next_state = AHWP_IDLE;
                end
            end
            AHWP_WR_WAIT:
            begin
                // Host may already have started another access
                if (wr_event && eff_cls != AHWP_CLS_NONE)
                begin
                    next_pend_wr = 1'b1;
                    next_pend_addr = eff_addr;
                    next_pend_be_n = eff_be_n;
                    next_pend_data = s_data;
                    next_pend_cls = eff_cls;
                end
                if (cnt == 3'h0)
                begin
                    next_ready = 1'b1;
                    next_state = AHWP_IDLE;
                end
                else
                begin
                    next_cnt = cnt - 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            state <= AHWP_IDLE;
            cnt <= 3'h0;
            lat_addr <= '0;
            lat_qual <= `AHWP_PIN_RST;
            lat_be_n <= '1;
            wr_n_prev <= `AHWP_PIN_RST;
            rd_cap <= 1'b0;
            pend_wr <= 1'b0;
            pend_addr <= '0;
            pend_be_n <= '1;
            pend_data <= '0;
            pend_cls <= AHWP_CLS_NONE;
            data_o <= DATA_W'(`AHWP_DATA_RST);
            data_oe_o <= 1'b0;
            async_ready_o <= `AHWP_READY_RST;
            core_rd_o <= 1'b0;
            core_wr_o <= 1'b0;
            core_addr_o <= '0;
            core_be_o <= '0;
            core_wdata_o <= '0;
            core_qdata_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            lat_addr <= next_lat_addr;
            lat_qual <= next_lat_qual;
            lat_be_n <= next_lat_be_n;
            wr_n_prev <= next_wr_n_prev;
            rd_cap <= next_rd_cap;
            pend_wr <= next_pend_wr;
            pend_addr <= next_pend_addr;
            pend_be_n <= next_pend_be_n;
            pend_data <= next_pend_data;
            pend_cls <= next_pend_cls;
            data_o <= next_data;
            data_oe_o <= next_oe;
            async_ready_o <= next_ready;
            core_rd_o <= next_core_rd;
            core_wr_o <= next_core_wr;
            core_addr_o <= next_core_addr;
            core_be_o <= next_core_be;
            core_wdata_o <= next_core_wdata;
            core_qdata_o <= next_core_qdata;
        end
    end
endmodule
`default_nettype wire

// [verilog/ahwp_params.svh]
/*
 Timing counts, decode addresses and reset values of the asynchronous
 host port. Assumes a 40 MHz core clock on the host port logic.
*/
`ifndef AHWP_PARAMS_SVH
`define AHWP_PARAMS_SVH

`define AHWP_CLK_PERIOD_NS 25
`define AHWP_RD_WAIT_NORMAL_NS 80
`define AHWP_RD_WAIT_TURBO_NS 40
`define AHWP_WR_WAIT_NS 36
`define AHWP_WR_WAIT_MAX_NS 50
// Least times round up to whole cycles
`define AHWP_RD_WAIT_NORMAL_CYC ((`AHWP_RD_WAIT_NORMAL_NS + `AHWP_CLK_PERIOD_NS - 1) / `AHWP_CLK_PERIOD_NS)
`define AHWP_RD_WAIT_TURBO_CYC ((`AHWP_RD_WAIT_TURBO_NS + `AHWP_CLK_PERIOD_NS - 1) / `AHWP_CLK_PERIOD_NS)
`define AHWP_WR_WAIT_CYC ((`AHWP_WR_WAIT_NS + `AHWP_CLK_PERIOD_NS - 1) / `AHWP_CLK_PERIOD_NS)
`define AHWP_WR_WAIT_MAX_CYC (`AHWP_WR_WAIT_MAX_NS / `AHWP_CLK_PERIOD_NS)

`define AHWP_BANK_SEL_ADDR 15'h0007
`define AHWP_QDATA_ADDR 15'h0004

`define AHWP_READY_RST 1'b1
`define AHWP_DATA_RST 32'h0000_0000
`define AHWP_PIN_RST 1'b1

`endif

// [verilog/ahwp_pkg.sv]
/*
 Types shared by the host port: access classes and sequencer states.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package ahwp_pkg;
    typedef enum logic [1:0] {AHWP_CLS_NONE, AHWP_CLS_BANK, AHWP_CLS_QDATA, AHWP_CLS_PLAIN} ahwp_cls_t;
    typedef enum logic [1:0] {AHWP_IDLE, AHWP_RD_WAIT, AHWP_RD_HOLD, AHWP_WR_WAIT} ahwp_state_t;
endpackage
`default_nettype wire

// [verilog/ahwp_sync.sv]
/*
 Two-flop synchroniser for a bundle of host pins.
 Assumes the inputs are asynchronous to ref_clk_i.
*/
`default_nettype none
module ahwp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // Idle high so strobes read inactive out of reset
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            meta <= '1;
            q_o <= '1;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// [tb/ahwp_port_assertions.sv]
/*
 Checker of ready wait lengths, request latency and read data timing.
 Assumes it is bound to ahwp_port and sees only its ports.
*/
`default_nettype none
module ahwp_port_checker #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic addr_qualifier_i,
    input wire logic addr_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic data_port_select_n_i,
    input wire logic turbo_mode_i,
    input wire logic async_ready_o,
    input wire logic [DATA_W-1:0] data_o,
    input wire logic data_oe_o,
    input wire logic core_rd_o,
    input wire logic core_wr_o,
    input wire logic core_qdata_o,
    input wire logic [DATA_W-1:0] core_rdata_i
);
    wire logic sel;
    assign sel = !addr_qualifier_i || !data_port_select_n_i;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence q_read;
        core_rd_o && core_qdata_o;
    endsequence
    sequence rd_start;
        $fell(read_strobe_n_i) && write_strobe_n_i && async_ready_o;
    endsequence
    rd_norm_wait_a: assert property (q_read ##0 !turbo_mode_i |-> !async_ready_o [*4] ##1 async_ready_o)
        else $error("normal queue read wait wrong");
    rd_turbo_wait_a: assert property (q_read ##0 turbo_mode_i |-> !async_ready_o [*2] ##1 async_ready_o)
        else $error("turbo queue read wait wrong");
    wr_wait_len_a: assert property (core_wr_o && core_qdata_o |-> !async_ready_o [*2] ##1 async_ready_o)
        else $error("queue write wait wrong");
    no_wait_a: assert property ((core_rd_o || core_wr_o) && !core_qdata_o |-> async_ready_o [*3])
        else $error("ready dropped on zero wait access");
    rd_latency_a: assert property (rd_start ##0 sel |-> ##3 core_rd_o)
        else $error("read request late");
    wr_latency_a: assert property ($rose(write_strobe_n_i) && sel |-> ##3 core_wr_o)
        else $error("write request late");
    rd_data_a: assert property (core_rd_o |-> data_oe_o ##2 data_o == $past(core_rdata_i, 1))
        else $error("read data not presented");
    idle_ready_a: assert property ($fell(async_ready_o) |-> core_rd_o || core_wr_o)
        else $error("ready fell without request");
    // Pin qualifier only decides in transparent mode; a latched address may still select
    refused_a: assert property ($fell(read_strobe_n_i) && !sel && !addr_strobe_n_i |-> !core_rd_o [*5])
        else $error("unaddressed read taken");
endmodule
bind ahwp_port ahwp_port_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_qualifier_i(addr_qualifier_i),
    .addr_strobe_n_i(addr_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .data_port_select_n_i(data_port_select_n_i), .turbo_mode_i(turbo_mode_i),
    .async_ready_o(async_ready_o), .data_o(data_o), .data_oe_o(data_oe_o), .core_rd_o(core_rd_o),
    .core_wr_o(core_wr_o), .core_qdata_o(core_qdata_o), .core_rdata_i(core_rdata_i));
`default_nettype wire

// [tb/ahwp_core_model.sv]
/*
 Core side model: answers reads one cycle after the request, logs writes.
 Assumes the port's core signals and its clock.
*/
`default_nettype none
module ahwp_core_model (
    input wire logic ref_clk_i,
    input wire logic core_rd_i,
    input wire logic core_wr_i,
    input wire logic [14:0] core_addr_i,
    input wire logic [3:0] core_be_i,
    input wire logic [31:0] core_wdata_i,
    output logic [31:0] core_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [14:0] wr_addr = 15'h0000;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [3:0] wr_be = 4'h0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    initial core_rdata_o = 32'h0000_0000;
    always @(posedge ref_clk_i)
    begin
        // Data only meaningful one cycle after a request; scrambled otherwise
        core_rdata_o <= core_rd_i ? {~core_addr_i, 2'b01, core_addr_i} : ~core_rdata_o;
        rd_cnt <= rd_cnt + int'(core_rd_i);
        if (core_wr_i)
        begin
            wr_addr <= core_addr_i;
            wr_data <= core_wdata_i;
            wr_be <= core_be_i;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
 Self-checking bench of the asynchronous host port with ready waits.
 Assumes the core model answers reads one cycle after the request.
*/
`include "ahwp_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [14:0] addr = 15'h0000;
    logic qual = 1'b1;
    logic [3:0] be_n = 4'h0;
    logic as_n = 1'b0;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic dsel_n = 1'b1;
    logic [31:0] din = 32'h0000_0000;
    logic turbo = 1'b0;
    logic [31:0] dout, cwdata, crdata;
    logic [14:0] caddr;
    logic [3:0] cbe;
    logic oe, ready, crd, cwr, cq;
    int miscompares = 0;
    int checks_done = 0;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
    always #12.5 clk = ~clk;
    ahwp_port dut (.ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .addr_qualifier_i(qual),
        .byte_lane_enables_n_i(be_n), .addr_strobe_n_i(as_n), .read_strobe_n_i(rd_n),
        .write_strobe_n_i(wr_n), .data_port_select_n_i(dsel_n), .data_i(din), .data_o(dout),
        .data_oe_o(oe), .async_ready_o(ready), .turbo_mode_i(turbo), .core_rd_o(crd),
        .core_wr_o(cwr), .core_addr_o(caddr), .core_be_o(cbe), .core_wdata_o(cwdata),
        .core_qdata_o(cq), .core_rdata_i(crdata));
    ahwp_core_model core (.ref_clk_i(clk), .core_rd_i(crd), .core_wr_i(cwr), .core_addr_i(caddr),
        .core_be_i(cbe), .core_wdata_i(cwdata), .core_rdata_o(crdata));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Read; addr pins left alone when the address was latched by strobe
    task automatic rd(input logic [14:0] a, input logic set_a, input logic [14:0] ea, input int ok, input int lows);
        int i;
        int n;
        int c0;
        n = 0;
        c0 = core.rd_cnt;
        @(negedge clk);
        if (set_a)
            addr = a;
        rd_n = 1'b0;
        for (i = 0; i < 30; i++)
        begin
            @(negedge clk);
            n += int'(!ready);
            if (i >= 7 && ready)
                break;
        end
        if (i == 30)
        begin
            miscompares++;
            end_sim();
        end
        `CHK("read wait", lows, n)
        `CHK("read count", ok, core.rd_cnt - c0)
        if (ok == 1)
            `CHK("read data", {~ea, 2'b01, ea}, dout)
        rd_n = 1'b1;
        cyc(4);
    endtask
    task automatic wr(input logic [14:0] a, input logic [31:0] d, input int lows, input logic look);
        int n;
        n = 0;
        @(negedge clk);
        addr = a;
        din = d;
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        if (look)
        begin
            repeat (6)
            begin
                @(negedge clk);
                n += int'(!ready);
            end
            `CHK("write wait", lows, n)
            `CHK("write addr", a, core.wr_addr)
            `CHK("write data", d, core.wr_data)
            `CHK("write lanes", ~be_n, core.wr_be)
        end
        else
        begin
            // Strobe stays high three cycles before the next access
            cyc(2);
        end
    endtask
    task automatic t_reset();
        `CHK("ready at reset", 1'b1, ready)
        `CHK("oe at reset", 1'b0, oe)
        `CHK("data at reset", 32'h0000_0000, dout)
    endtask
    task automatic t_reads();
        qual = 1'b0;
        rd(`AHWP_BANK_SEL_ADDR, 1'b1, `AHWP_BANK_SEL_ADDR, 1, 0);
        rd(`AHWP_QDATA_ADDR, 1'b1, `AHWP_QDATA_ADDR, 1, 4);
        turbo = 1'b1;
        rd(`AHWP_QDATA_ADDR, 1'b1, `AHWP_QDATA_ADDR, 1, 2);
        turbo = 1'b0;
        rd(15'h0012, 1'b1, 15'h0012, 1, 0);
    endtask
    task automatic t_writes();
        int c0;
        be_n = 4'h5;
        wr(`AHWP_QDATA_ADDR, 32'hA5C3_0F1E, 2, 1'b1);
        wr(`AHWP_BANK_SEL_ADDR, 32'h0000_0003, 0, 1'b1);
        c0 = core.wr_cnt;
        wr(`AHWP_QDATA_ADDR, 32'h1111_2222, 2, 1'b0);
        wr(`AHWP_QDATA_ADDR, 32'h3333_4444, 2, 1'b1);
        `CHK("write count", 2, core.wr_cnt - c0)
        be_n = 4'h0;
    endtask
    task automatic t_select();
        qual = 1'b1;
        dsel_n = 1'b0;
        rd(15'h0012, 1'b1, 15'h0012, 1, 4);
        dsel_n = 1'b1;
        rd(`AHWP_QDATA_ADDR, 1'b1, `AHWP_QDATA_ADDR, 0, 0);
    endtask
    task automatic t_strobe();
        @(negedge clk);
        as_n = 1'b1;
        cyc(2);
        addr = `AHWP_BANK_SEL_ADDR;
        qual = 1'b0;
        as_n = 1'b0;
        cyc(2);
        as_n = 1'b1;
        cyc(2);
        addr = `AHWP_QDATA_ADDR;
        qual = 1'b1;
        rd(15'h0000, 1'b0, `AHWP_BANK_SEL_ADDR, 1, 0);
        as_n = 1'b0;
    endtask
    initial
    begin
        cyc(16);
        rst_b = 1'b1;
        t_reset();
        t_reads();
        t_writes();
        t_select();
        t_strobe();
        end_sim();
    end
endmodule
`default_nettype wire
